/* hdl/abf_port.sv */
// asynchronous byte fifo host port of one channel
`timescale 1ns/1ns
module abf_port
    import abf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic mode_en_i,
    input wire logic wake_en_i,
    input wire logic powered_state_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic flush_or_wake_n_i,
    input wire logic [ABF_DATA_W-1:0] data_i,
    output logic [ABF_DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic rx_avail_n_o,
    output logic rx_avail_n_oe_o,
    output logic tx_space_n_o,
    output logic tx_space_n_oe_o,
    input wire logic [ABF_DATA_W-1:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    output logic [ABF_DATA_W-1:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic flush_req_o,
    output logic resume_req_o
);
    logic [ABF_STROBE_N-1:0] strobe_s;
    logic [ABF_STROBE_N-1:0] strobe_prev_q;
    logic rd_s;
    logic wr_s;
    logic fw_s;
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic fw_fall;
    logic mode_q;
    logic mode_d;
    logic [ABF_DATA_W-1:0] head_q;
    logic [ABF_DATA_W-1:0] head_d;
    logic rx_full_q;
    logic rx_full_d;
    logic rx_ready_q;
    logic rx_ready_d;
    logic [ABF_DATA_W-1:0] data_q;
    logic [ABF_DATA_W-1:0] data_d;
    logic data_oe_q;
    logic data_oe_d;
    logic rx_avail_n_q;
    logic rx_avail_n_d;
    logic tx_space_n_q;
    logic tx_space_n_d;
    logic flag_oe_q;
    logic [ABF_DATA_W-1:0] tx_data_q;
    logic [ABF_DATA_W-1:0] tx_data_d;
    logic tx_valid_q;
    logic tx_valid_d;
    logic flush_q;
    logic flush_d;
    logic resume_q;
    logic resume_d;

    ////////////////////////////////////////////////////////////////////////////
    // strobe synchronisers and edge detection on the second stage only
    abf_sync u_sync
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .async_i({flush_or_wake_n_i, wr_n_i, rd_n_i}),
        .sync_o(strobe_s)
    );

    // previous values reset idle high, so releasing reset never fakes a strobe edge
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            strobe_prev_q <= ABF_STROBE_RST;
        else
            strobe_prev_q <= strobe_s;
    end

    // edges gated by the mode so a disabled channel ignores its pins
    always_comb
    begin
        rd_s = strobe_s[ABF_IDX_RD];
        wr_s = strobe_s[ABF_IDX_WR];
        fw_s = strobe_s[ABF_IDX_FW];
        rd_fall = mode_q & strobe_prev_q[ABF_IDX_RD] & ~rd_s;
        rd_rise = mode_q & ~strobe_prev_q[ABF_IDX_RD] & rd_s;
        wr_fall = mode_q & strobe_prev_q[ABF_IDX_WR] & ~wr_s;
        fw_fall = mode_q & strobe_prev_q[ABF_IDX_FW] & ~fw_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive side: head byte, read data lines and receive flag
    always_comb
    begin
        mode_d = mode_en_i;
        head_d = head_q;
        rx_full_d = rx_full_q;
        // the rising strobe wins: a held byte is released before a new one is fetched
        if (rd_rise)
            rx_full_d = 1'b0;
        else if (rx_valid_i && rx_ready_q)
        begin
            head_d = rx_data_i;
            rx_full_d = 1'b1;
        end
        // only fetch while the strobe is high so the driven byte never changes
        rx_ready_d = mode_q & ~rx_full_d & rd_s;
        data_d = rd_fall ? head_q : data_q;
        data_oe_d = mode_q & ~rd_s;
        // forced high on the rising strobe, low only while a byte waits
        rx_avail_n_d = ~mode_q | rd_rise | ~rx_full_q;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mode_q <= 1'b0;
            head_q <= ABF_DATA_RST;
            rx_full_q <= 1'b0;
            rx_ready_q <= 1'b0;
            data_q <= ABF_DATA_RST;
            data_oe_q <= 1'b0;
            rx_avail_n_q <= 1'b1;
        end
        else
        begin
            mode_q <= mode_d;
            head_q <= head_d;
            rx_full_q <= rx_full_d;
            rx_ready_q <= rx_ready_d;
            data_q <= data_d;
            data_oe_q <= data_oe_d;
            rx_avail_n_q <= rx_avail_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit side: capture on write strobe fall, hold until drained
    always_comb
    begin
        tx_data_d = tx_data_q;
        tx_valid_d = tx_valid_q;
        if (tx_valid_q && tx_ready_i)
            tx_valid_d = 1'b0;
        // a fall while a byte is pending is dropped; the busy flag told the host to wait
        if (wr_fall && !tx_valid_q)
        begin
            tx_data_d = data_i;
            tx_valid_d = 1'b1;
        end
        // busy as soon as a byte is taken, free on the same edge that it drains
        tx_space_n_d = ~mode_q | tx_valid_d;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_data_q <= ABF_DATA_RST;
            tx_valid_q <= 1'b0;
            tx_space_n_q <= 1'b1;
        end
        else
        begin
            tx_data_q <= tx_data_d;
            tx_valid_q <= tx_valid_d;
            tx_space_n_q <= tx_space_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flush/wake: one-cycle requests chosen by the powered state
    always_comb
    begin
        // suspended with wakeup disabled, the pin does nothing at all
        resume_d = fw_fall & powered_state_n_i & wake_en_i;
        flush_d = fw_fall & ~powered_state_n_i;
    end

    // flag enables are low through reset so the external pull-up holds them high
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            flush_q <= 1'b0;
            resume_q <= 1'b0;
            flag_oe_q <= 1'b0;
        end
        else
        begin
            flush_q <= flush_d;
            resume_q <= resume_d;
            flag_oe_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops
    assign data_o = data_q;
    assign data_oe_o = data_oe_q;
    assign rx_avail_n_o = rx_avail_n_q;
    assign rx_avail_n_oe_o = flag_oe_q;
    assign tx_space_n_o = tx_space_n_q;
    assign tx_space_n_oe_o = flag_oe_q;
    assign rx_ready_o = rx_ready_q;
    assign tx_data_o = tx_data_q;
    assign tx_valid_o = tx_valid_q;
    assign flush_req_o = flush_q;
    assign resume_req_o = resume_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions and covers
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_mode_gate: assert property (!mode_q |=> !data_oe_o && rx_avail_n_o && tx_space_n_o)
        else $error("disabled channel drives lines or flags");
    a_oe_read_low: assert property (data_oe_o |-> $past(mode_q) && !$past(rd_s))
        else $error("data lines driven without read strobe low");
    a_rx_flag_byte: assert property (!rx_avail_n_o |-> $past(rx_full_q))
        else $error("receive flag low with no byte held");
    a_rx_flag_rise: assert property (rd_rise |=> rx_avail_n_o && !rx_full_q ##1 rx_avail_n_o)
        else $error("receive flag not forced high after read");
    a_read_head: assert property (rd_fall |=> data_o == $past(head_q) ##1 data_oe_o || rd_s)
        else $error("head byte not presented on read");
    a_rx_advance: assert property (rd_rise |=> !rx_full_q)
        else $error("receive data did not advance");
    a_tx_capture: assert property (wr_fall && !tx_valid_q |=> tx_valid_o && tx_data_o == $past(data_i))
        else $error("write byte not captured");
    a_tx_flag_busy: assert property (tx_valid_o |-> tx_space_n_o)
        else $error("transmit flag low while byte pending");
    a_wake_resume: assert property (fw_fall && powered_state_n_i && wake_en_i |=> resume_req_o && !flush_req_o)
        else $error("resume not requested");
    a_flush_send: assert property (fw_fall && !powered_state_n_i |=> flush_req_o ##1 !flush_req_o)
        else $error("flush not a single pulse");
    a_sync_delay: assert property (mode_q && $fell(rd_n_i) ##1 !rd_n_i ##1 !rd_n_i |-> !rd_s)
        else $error("read strobe not through two stages");
    // flag drivers come on at the first edge after reset and stay on
    a_flag_oe_run: assert property ($past(rst_b_i) |-> rx_avail_n_oe_o && tx_space_n_oe_o)
        else $error("flag enable low outside reset");
    // the driven byte never changes under an open read
    a_data_steady: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
        else $error("driven byte changed during read");
    // a fetched byte becomes the held head
    a_head_load: assert property (rx_valid_i && rx_ready_o |=> rx_full_q && head_q == $past(rx_data_i))
        else $error("fetched byte not held");
    // a held byte stays put until its read ends
    a_head_hold: assert property (rx_full_q && !rd_rise |=> rx_full_q && $stable(head_q))
        else $error("held byte lost before read end");
    // fetching only with an empty head in an enabled channel
    a_ready_empty: assert property (rx_ready_o |-> !rx_full_q && $past(mode_q))
        else $error("fetch offered while head full");
    // a low receive flag stays low until the read completes
    a_rx_flag_hold: assert property (!rx_avail_n_o && mode_q && !rd_rise |=> !rx_avail_n_o)
        else $error("receive flag rose without a read");
    // a pending byte and its data wait for the transmit buffer
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("pending byte dropped or changed");
    // one accepted byte leaves the holding register
    a_tx_drain: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
        else $error("byte not released after drain");
    // a free flag means nothing pending in an enabled channel
    a_space_free: assert property (!tx_space_n_o |-> !tx_valid_o && $past(mode_q))
        else $error("transmit flag low while busy");
    // suspended without wakeup enabled, no resume is asked for
    a_wake_quiet: assert property (fw_fall && powered_state_n_i && !wake_en_i |=> !resume_req_o)
        else $error("resume while wakeup disabled");
    // a resume request lasts a single cycle
    a_resume_once: assert property (resume_req_o |=> !resume_req_o)
        else $error("resume request longer than one cycle");
    // a suspended device never flushes
    a_flush_quiet: assert property (fw_fall && powered_state_n_i |=> !flush_req_o)
        else $error("flush while suspended");

    // covers for the main scenarios
    c_read: cover property (rd_fall ##[1:20] rd_rise);
    c_write: cover property (wr_fall ##1 tx_valid_o);
    c_resume: cover property (resume_req_o);
    c_flush: cover property (flush_req_o && tx_valid_o);
    c_wake_quiet: cover property (fw_fall && powered_state_n_i && !wake_en_i);
endmodule

/* hdl/abf_pkg.sv */
// constants shared by the asynchronous byte fifo port
package abf_pkg;
    localparam int ABF_DATA_W = 8;            // width of the data lines
    localparam int ABF_SYNC_STAGES = 2;       // flip-flops per strobe synchroniser
    localparam int ABF_STROBE_N = 3;          // read strobe, write strobe, flush/wake
    localparam int ABF_IDX_RD = 0;            // read strobe position in the strobe vector
    localparam int ABF_IDX_WR = 1;            // write strobe position
    localparam int ABF_IDX_FW = 2;            // flush/wake position
    localparam logic [ABF_DATA_W-1:0] ABF_DATA_RST = 8'h00;   // data registers after reset
    localparam logic [ABF_STROBE_N-1:0] ABF_STROBE_RST = 3'h7; // strobes idle high after reset
endpackage

/* hdl/abf_sync.sv */
// two flip-flop synchroniser for the asynchronous strobe inputs
`timescale 1ns/1ns
module abf_sync
    import abf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [ABF_STROBE_N-1:0] async_i,
    output logic [ABF_STROBE_N-1:0] sync_o
);
    logic [ABF_STROBE_N-1:0] meta_q;
    logic [ABF_STROBE_N-1:0] sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // one pair of flip-flops per strobe; the first stage feeds only the second
    for (genvar g = 0; g < ABF_STROBE_N; g++)
    begin : g_bit
        always_ff @(posedge clk_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
            begin
                meta_q[g] <= ABF_STROBE_RST[g];
                sync_q[g] <= ABF_STROBE_RST[g];
            end
            else
            begin
                meta_q[g] <= async_i[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end

    assign sync_o = sync_q;
endmodule

/* verif/abf_host_model.sv */
// host model that strobes the byte port and resolves the shared data lines
`timescale 1ns/1ns
module abf_host_model
    import abf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rx_avail_n_i,
    input wire logic tx_space_n_i,
    input wire logic [ABF_DATA_W-1:0] dev_data_i,
    input wire logic dev_oe_i,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [ABF_DATA_W-1:0] bus_o
);
    logic [ABF_DATA_W-1:0] host_d;
    logic host_oe;
    logic timed_out;
    // released lines show the inverse of the last host byte, never a stale copy
    assign bus_o = dev_oe_i ? dev_data_i : (host_oe ? host_d : ~host_d);
    ////////////////////////////////////////////////////////////////
    // idle strobes high
    initial
    begin
        rd_n_o = 1'h1;
        wr_n_o = 1'h1;
        host_d = 8'h00;
        host_oe = 1'h0;
        timed_out = 1'h0;
    end
    // bounded wait for a low flag: sel 0 receive, sel 1 transmit
    task automatic wait_low(input logic sel);
        int n;
        n = 0;
        while ((sel ? tx_space_n_i : rx_avail_n_i) !== 1'h0 && n < 60)
        begin
            @(negedge clk_i);
            n++;
        end
        timed_out = (n >= 60);
    endtask
    // one read pulse, called at a falling clock edge
    task automatic rd_cycle(output logic [ABF_DATA_W-1:0] got, output logic oe_on, output logic hi, output logic oe_off);
        wait_low(1'h0);
        rd_n_o = 1'h0;
        repeat (4) @(negedge clk_i);
        got = bus_o;
        oe_on = dev_oe_i;
        rd_n_o = 1'h1;
        hi = 1'h0;
        repeat (4)
        begin
            @(negedge clk_i);
            hi = hi | rx_avail_n_i;
        end
        oe_off = dev_oe_i;
    endtask
    // one write pulse; data held well past the fall
    task automatic wr_cycle(input logic [ABF_DATA_W-1:0] b);
        wait_low(1'h1);
        host_d = b;
        host_oe = 1'h1;
        wr_n_o = 1'h0;
        repeat (4) @(negedge clk_i);
        wr_n_o = 1'h1;
        @(negedge clk_i);
        host_oe = 1'h0;
        repeat (3) @(negedge clk_i);
    endtask
endmodule

/* verif/abf_port_tb.sv */
// self-checking bench for the asynchronous byte fifo port
`timescale 1ns/1ns
module abf_port_tb
    import abf_pkg::*;
;
    logic clk_i, rst_b_i, mode_en, wake_en, pwr_n, fw_n, rx_valid, tx_ready;
    logic rd_n, wr_n, data_oe, rx_av, rx_av_oe, tx_sp, tx_sp_oe, rx_ready, tx_valid, flush_req, resume_req;
    logic [ABF_DATA_W-1:0] rx_data, bus, data_o, tx_data;
    logic [7:0] flush_cnt, resume_cnt;
    logic [ABF_DATA_W-1:0] rx_src[$], rx_exp[$], tx_exp[$];
    int err_total, total_checks;
    int seed;
    abf_port abf_port_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .mode_en_i(mode_en), .wake_en_i(wake_en),
        .powered_state_n_i(pwr_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .flush_or_wake_n_i(fw_n), .data_i(bus),
        .data_o(data_o), .data_oe_o(data_oe), .rx_avail_n_o(rx_av), .rx_avail_n_oe_o(rx_av_oe),
        .tx_space_n_o(tx_sp), .tx_space_n_oe_o(tx_sp_oe), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
        .rx_ready_o(rx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .flush_req_o(flush_req), .resume_req_o(resume_req));
    abf_host_model abf_host_model_i (.clk_i(clk_i), .rx_avail_n_i(rx_av), .tx_space_n_i(tx_sp),
        .dev_data_i(data_o), .dev_oe_i(data_oe), .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(bus));
    ////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic final_report();
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // byte compare
    task automatic chk_b(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    // flag compare
    task automatic chk_f(input string what, input logic exp, input logic got);
        chk_b(what, {7'h00, exp}, {7'h00, got});
    endtask
    ////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial
    begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    // internal buffers, pulse counters and reset flag checks, driven at falling edges
    always @(negedge clk_i)
    begin
        rx_valid = (rx_src.size() > 0);
        rx_data = rx_valid ? rx_src[0] : ABF_DATA_W'($random(seed));
        if (rx_valid && rx_ready === 1'h1)
            rx_exp.push_back(rx_src.pop_front());
        tx_ready = 1'($random(seed));
        if (tx_valid === 1'h1 && tx_ready)
        begin
            chk_b("tx_data", tx_exp.pop_front(), tx_data);
            chk_f("tx_space_busy", 1'h1, tx_sp);
        end
        flush_cnt = flush_cnt + 8'(flush_req === 1'h1);
        resume_cnt = resume_cnt + 8'(resume_req === 1'h1);
        if (rst_b_i === 1'h0)
            chk_f("flag_oe_rst", 1'h0, rx_av_oe | tx_sp_oe);
    end
    // watchdog
    initial
    begin
        #300000;
        err_total++;
        final_report();
    end
    // main sequence
    initial
    begin
        logic [ABF_DATA_W-1:0] b;
        logic on, hi, off;
        seed = 32'hf07e_855e;
        {rst_b_i, mode_en, wake_en, pwr_n, fw_n} = 5'h0f;
        {flush_cnt, resume_cnt} = 16'h0000;
        repeat (3) @(negedge clk_i);
        rst_b_i = 1'h1;
        repeat (3) @(negedge clk_i);
        chk_f("flag_oe", 1'h1, rx_av_oe & tx_sp_oe);
        rx_src = '{8'h00, 8'hff};
        repeat (4) rx_src.push_back(ABF_DATA_W'($random(seed)));
        for (int i = 0; i < 7; i++)
        begin
            if (i == 6)
            begin
                mode_en = 1'h0;
                {flush_cnt, resume_cnt} = 16'h0000;
                fw_n = 1'h0;
                rx_src.push_back(8'h5a);
                repeat (12) @(negedge clk_i);
                chk_f("off_flags", 1'h1, rx_av & tx_sp & ~data_oe);
                chk_b("off_pulses", 8'h00, flush_cnt | resume_cnt);
                fw_n = 1'h1;
                mode_en = 1'h1;
            end
            abf_host_model_i.rd_cycle(b, on, hi, off);
            chk_f("rx_wait", 1'h0, abf_host_model_i.timed_out);
            chk_b("rx_data", rx_exp.pop_front(), b);
            chk_f("data_oe_low", 1'h1, on);
            chk_f("data_oe_high", 1'h0, off);
            chk_f("rx_flag_rise", 1'h1, hi);
        end
        repeat (6) @(negedge clk_i);
        chk_f("rx_empty", 1'h1, rx_av);
        for (int i = 0; i < 8; i++)
        begin
            b = (i < 2) ? {8{i[0]}} : ABF_DATA_W'($random(seed));
            tx_exp.push_back(b);
            abf_host_model_i.wr_cycle(b);
            chk_f("tx_wait", 1'h0, abf_host_model_i.timed_out);
        end
        repeat (20) @(negedge clk_i);
        chk_f("tx_drained", 1'h1, tx_exp.size() == 0);
        for (int k = 0; k < 3; k++)
        begin
            pwr_n = (k != 0);
            wake_en = (k != 2);
            {flush_cnt, resume_cnt} = 16'h0000;
            fw_n = 1'h0;
            repeat (4) @(negedge clk_i);
            fw_n = 1'h1;
            repeat (6) @(negedge clk_i);
            chk_b("flush_pulses", 8'(k == 0), flush_cnt);
            chk_b("resume_pulses", 8'(k == 1), resume_cnt);
        end
        final_report();
    end
endmodule
